//--- src/ptp_ctl_pkg.sv
// constants for the ptp system time control block
// assumes one 20 MHz clock and a plain register port
package ptp_ctl_pkg;
    localparam logic [3:0]  OFS_CTRL      = 4'h0;
    localparam logic [3:0]  OFS_ADDEND    = 4'h1;
    localparam logic [3:0]  OFS_SEC_UPD   = 4'h2;
    localparam logic [3:0]  OFS_NS_UPD    = 4'h3;
    localparam logic [3:0]  OFS_TGT_SEC   = 4'h4;
    localparam logic [3:0]  OFS_TGT_NS    = 4'h5;
    localparam logic [3:0]  OFS_SEC       = 4'h6;
    localparam logic [3:0]  OFS_NS        = 4'h7;
    localparam logic [3:0]  OFS_INC       = 4'h8;
    localparam logic [3:0]  OFS_STATUS    = 4'h9;
    localparam int BIT_TS_ON      = 0;
    localparam int BIT_FINE       = 1;
    localparam int BIT_INIT       = 2;
    localparam int BIT_UPDATE     = 3;
    localparam int BIT_TGT_ARM    = 4;
    localparam int BIT_ADDEND     = 5;
    localparam int BIT_ALL_FRAMES = 8;
    localparam int BIT_DIGITAL    = 9;
    localparam int BIT_EVENT_ONLY = 14;
    localparam int BIT_MASTER     = 15;
    localparam int BIT_CLK_LO     = 16;
    localparam int BIT_SUB        = 31;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK    = 32'h0003_C33F;
    localparam logic [30:0] DIGITAL_MAX   = 31'h3B9A_C9FF;
    localparam logic [30:0] BINARY_MAX    = 31'h7FFF_FFFF;
    localparam logic [3:0] MSG_SYNC       = 4'h0;
    localparam logic [3:0] MSG_DELAY_REQ  = 4'h1;
    localparam logic [3:0] MSG_PDLY_REQ   = 4'h2;
    localparam logic [3:0] MSG_PDLY_RESP  = 4'h3;
    localparam logic [3:0] MSG_FOLLOW_UP  = 4'h8;
    localparam logic [3:0] MSG_DELAY_RESP = 4'h9;
    typedef enum logic [1:0] {
        CLK_ORDINARY, CLK_BOUNDARY, CLK_E2E, CLK_P2P
    } clock_type_t;
endpackage : ptp_ctl_pkg

//--- src/ptp_msg_filter.sv
// snapshot selection from message type and control settings
// assumes the parser supplies a valid frame and its message type
module ptp_msg_filter (
    // settings
    input  wire logic [1:0] clock_type_select,
    input  wire logic       event_only_snapshot,
    input  wire logic       master_message_select,
    // frame
    input  wire logic [3:0] msg_type,
    output logic            take
);
    always_comb begin
        take = 1'b0;
        unique case (ptp_ctl_pkg::clock_type_t'(clock_type_select))
            ptp_ctl_pkg::CLK_ORDINARY, ptp_ctl_pkg::CLK_BOUNDARY: begin
                if (!event_only_snapshot)
                    take = msg_type == ptp_ctl_pkg::MSG_SYNC ||
                           msg_type == ptp_ctl_pkg::MSG_FOLLOW_UP ||
                           msg_type == ptp_ctl_pkg::MSG_DELAY_REQ ||
                           msg_type == ptp_ctl_pkg::MSG_DELAY_RESP;
                else if (master_message_select)
                    take = msg_type == ptp_ctl_pkg::MSG_DELAY_REQ;
                else
                    take = msg_type == ptp_ctl_pkg::MSG_SYNC;
            end
            ptp_ctl_pkg::CLK_E2E: begin
                take = msg_type == ptp_ctl_pkg::MSG_SYNC ||
                       msg_type == ptp_ctl_pkg::MSG_FOLLOW_UP ||
                       (!event_only_snapshot &&
                        (msg_type == ptp_ctl_pkg::MSG_DELAY_REQ ||
                         msg_type == ptp_ctl_pkg::MSG_DELAY_RESP));
            end
            ptp_ctl_pkg::CLK_P2P: begin
                take = msg_type == ptp_ctl_pkg::MSG_SYNC ||
                       msg_type == ptp_ctl_pkg::MSG_PDLY_REQ ||
                       msg_type == ptp_ctl_pkg::MSG_PDLY_RESP ||
                       (!event_only_snapshot &&
                        (msg_type == ptp_ctl_pkg::MSG_FOLLOW_UP ||
                         msg_type == ptp_ctl_pkg::MSG_DELAY_REQ ||
                         msg_type == ptp_ctl_pkg::MSG_DELAY_RESP));
            end
        endcase
    end
endmodule // ptp_msg_filter

//--- src/ptp_addend_acc.sv
// fine correction accumulator: carry out marks an increment tick
// assumes addend is already loaded by the control logic
module ptp_addend_acc #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    // control
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] addend,
    output logic                  carry
);
    typedef struct packed {
        logic [WIDTH-1:0] acc;
        logic             carry;
    } acc_state_t;
    acc_state_t s_r;
    acc_state_t s_nxt;
    always_comb begin
        s_nxt = s_r;
        s_nxt.carry = 1'b0;
        if (run)
            {s_nxt.carry, s_nxt.acc} = {1'b0, s_r.acc} + {1'b0, addend};
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
    assign carry = s_r.carry;
endmodule // ptp_addend_acc

//--- src/ptp_system_time_control.sv
// ptp system time counter, control register and snapshot selection
// assumes synchronous inputs on core_clk and a one-cycle read port
module ptp_system_time_control #(
    parameter int ADDEND_W = 32
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // receive frame events
    input  wire logic        rx_frame_end,
    input  wire logic        rx_is_ptp,
    input  wire logic [3:0]  rx_msg_type,
    // transmit frame events
    input  wire logic        tx_frame_end,
    input  wire logic        tx_ts_request,
    // snapshot outputs
    output logic             rx_snap_valid,
    output logic             tx_snap_valid,
    output logic      [31:0] snap_sec,
    output logic      [31:0] snap_ns,
    output logic             rx_ptp_process,
    // event
    output logic             target_time_irq
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] addend;
        logic [31:0] addend_used;
        logic [31:0] sec_upd;
        logic [31:0] ns_upd;
        logic [31:0] tgt_sec;
        logic [31:0] tgt_ns;
        logic [31:0] sec;
        logic [30:0] ns;
        logic [7:0]  inc;
        logic [31:0] rdata;
        logic        rx_snap;
        logic        tx_snap;
        logic [31:0] snap_sec;
        logic [31:0] snap_ns;
        logic        rx_proc;
        logic        irq;
        logic        tgt_hit;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    logic       take_msg;
    logic       fine_tick;
    logic       acc_run;
    logic [1:0] clk_sel;

    assign clk_sel = s_r.ctrl[ptp_ctl_pkg::BIT_CLK_LO +: 2];
    assign acc_run = s_r.ctrl[ptp_ctl_pkg::BIT_TS_ON]
                     & s_r.ctrl[ptp_ctl_pkg::BIT_FINE];

    ptp_msg_filter u_filter (
        .clock_type_select     (clk_sel),
        .event_only_snapshot   (s_r.ctrl[ptp_ctl_pkg::BIT_EVENT_ONLY]),
        .master_message_select (s_r.ctrl[ptp_ctl_pkg::BIT_MASTER]),
        .msg_type              (rx_msg_type),
        .take                  (take_msg)
    );

    ptp_addend_acc #(
        .WIDTH (ADDEND_W)
    ) u_acc (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .run      (acc_run),
        .addend   (s_r.addend_used[ADDEND_W-1:0]),
        .carry    (fine_tick)
    );

    // wrap-aware ns add, ns below max assumed
    function automatic logic [31:0] ns_wrap_add(
        input logic [30:0] a,
        input logic [30:0] b,
        input logic        dig,
        output logic       wrapped
    );
        logic [31:0] sum;
        logic [31:0] lim;
        sum = {1'b0, a} + {1'b0, b};
        lim = dig ? {1'b0, ptp_ctl_pkg::DIGITAL_MAX}
                  : {1'b0, ptp_ctl_pkg::BINARY_MAX};
        wrapped = sum > lim;
        ns_wrap_add = wrapped ? sum - lim - 32'h0000_0001 : sum;
    endfunction

    always_comb begin
        logic        dig;
        logic        on;
        logic        wrap;
        logic        borrow;
        logic [31:0] nsum;
        logic [31:0] lim;
        logic [31:0] now_ns;
        dig    = s_r.ctrl[ptp_ctl_pkg::BIT_DIGITAL];
        on     = s_r.ctrl[ptp_ctl_pkg::BIT_TS_ON];
        wrap   = 1'b0;
        borrow = 1'b0;
        nsum   = 32'h0000_0000;
        lim    = dig ? {1'b0, ptp_ctl_pkg::DIGITAL_MAX}
                     : {1'b0, ptp_ctl_pkg::BINARY_MAX};
        now_ns = {1'b0, s_r.ns};
        s_nxt = s_r;
        s_nxt.rx_snap = 1'b0;
        s_nxt.tx_snap = 1'b0;
        s_nxt.irq     = 1'b0;
        s_nxt.rdata   = 32'h0000_0000;

        // time counter advances only while enabled
        if (on && (s_r.ctrl[ptp_ctl_pkg::BIT_FINE] ? fine_tick
                                                    : 1'b1)) begin
            nsum = ns_wrap_add(s_r.ns, {23'h00_0000, s_r.inc}, dig, wrap);
            s_nxt.ns = nsum[30:0];
            if (wrap)
                s_nxt.sec = s_r.sec + 32'h0000_0001;
        end

        // init and update act on the seconds and ns words; no seconds high word here
        if (s_r.ctrl[ptp_ctl_pkg::BIT_INIT]) begin
            s_nxt.sec = s_r.sec_upd;
            s_nxt.ns  = s_r.ns_upd[30:0];
            s_nxt.ctrl[ptp_ctl_pkg::BIT_INIT] = 1'b0;
        end else if (s_r.ctrl[ptp_ctl_pkg::BIT_UPDATE]) begin
            if (s_r.ns_upd[ptp_ctl_pkg::BIT_SUB]) begin
                borrow = now_ns < {1'b0, s_r.ns_upd[30:0]};
                nsum = borrow
                    ? now_ns + lim + 32'h0000_0001 - {1'b0, s_r.ns_upd[30:0]}
                    : now_ns - {1'b0, s_r.ns_upd[30:0]};
                s_nxt.ns  = nsum[30:0];
                s_nxt.sec = s_r.sec - s_r.sec_upd
                            - {31'h0000_0000, borrow};
            end else begin
                nsum = ns_wrap_add(s_r.ns, s_r.ns_upd[30:0], dig, wrap);
                s_nxt.ns  = nsum[30:0];
                s_nxt.sec = s_r.sec + s_r.sec_upd
                            + {31'h0000_0000, wrap};
            end
            s_nxt.ctrl[ptp_ctl_pkg::BIT_UPDATE] = 1'b0;
        end

        // load bit copies the addend to the accumulator, then clears
        if (s_r.ctrl[ptp_ctl_pkg::BIT_ADDEND]) begin
            s_nxt.addend_used = s_r.addend;
            s_nxt.ctrl[ptp_ctl_pkg::BIT_ADDEND] = 1'b0;
        end

        // target time compare
        s_nxt.tgt_hit = (s_r.sec > s_r.tgt_sec) ||
                        (s_r.sec == s_r.tgt_sec &&
                         {1'b0, s_r.ns} > s_r.tgt_ns);
        if (s_r.ctrl[ptp_ctl_pkg::BIT_TGT_ARM] && s_r.tgt_hit) begin
            s_nxt.irq = 1'b1;
            s_nxt.ctrl[ptp_ctl_pkg::BIT_TGT_ARM] = 1'b0;
        end

        // snapshots
        s_nxt.rx_proc = on;
        if (on && rx_frame_end &&
            (s_r.ctrl[ptp_ctl_pkg::BIT_ALL_FRAMES] ||
             (rx_is_ptp && take_msg))) begin
            s_nxt.rx_snap  = 1'b1;
            s_nxt.snap_sec = s_r.sec;
            s_nxt.snap_ns  = {1'b0, s_r.ns};
        end else if (on && tx_frame_end && tx_ts_request) begin
            s_nxt.tx_snap  = 1'b1;
            s_nxt.snap_sec = s_r.sec;
            s_nxt.snap_ns  = {1'b0, s_r.ns};
        end

        // register writes; a ctrl write with a self-clearing bit at 0 clears that bit
        if (reg_wr) begin
            unique case (reg_addr)
                ptp_ctl_pkg::OFS_CTRL:
                    s_nxt.ctrl = (reg_wdata & ptp_ctl_pkg::CTRL_WMASK)
                        | (s_nxt.ctrl & 32'h0000_0038 & reg_wdata);
                ptp_ctl_pkg::OFS_ADDEND:  s_nxt.addend  = reg_wdata;
                ptp_ctl_pkg::OFS_SEC_UPD: s_nxt.sec_upd = reg_wdata;
                ptp_ctl_pkg::OFS_NS_UPD:  s_nxt.ns_upd  = reg_wdata;
                ptp_ctl_pkg::OFS_TGT_SEC: s_nxt.tgt_sec = reg_wdata;
                ptp_ctl_pkg::OFS_TGT_NS:  s_nxt.tgt_ns  = reg_wdata;
                ptp_ctl_pkg::OFS_INC:     s_nxt.inc     = reg_wdata[7:0];
                default: ;
            endcase
            // a ctrl write with init or update at 0 drops a busy init or update
            if (reg_addr == ptp_ctl_pkg::OFS_CTRL) begin
                s_nxt.ctrl[ptp_ctl_pkg::BIT_INIT] =
                    reg_wdata[ptp_ctl_pkg::BIT_INIT] |
                    s_nxt.ctrl[ptp_ctl_pkg::BIT_INIT];
                s_nxt.ctrl[ptp_ctl_pkg::BIT_UPDATE] =
                    reg_wdata[ptp_ctl_pkg::BIT_UPDATE] |
                    s_nxt.ctrl[ptp_ctl_pkg::BIT_UPDATE];
            end
        end

        if (reg_rd) begin
            unique case (reg_addr)
                ptp_ctl_pkg::OFS_CTRL:    s_nxt.rdata = s_r.ctrl;
                ptp_ctl_pkg::OFS_ADDEND:  s_nxt.rdata = s_r.addend;
                ptp_ctl_pkg::OFS_SEC_UPD: s_nxt.rdata = s_r.sec_upd;
                ptp_ctl_pkg::OFS_NS_UPD:  s_nxt.rdata = s_r.ns_upd;
                ptp_ctl_pkg::OFS_TGT_SEC: s_nxt.rdata = s_r.tgt_sec;
                ptp_ctl_pkg::OFS_TGT_NS:  s_nxt.rdata = s_r.tgt_ns;
                ptp_ctl_pkg::OFS_SEC:     s_nxt.rdata = s_r.sec;
                ptp_ctl_pkg::OFS_NS:      s_nxt.rdata = {1'b0, s_r.ns};
                ptp_ctl_pkg::OFS_INC:
                    s_nxt.rdata = {24'h00_0000, s_r.inc};
                ptp_ctl_pkg::OFS_STATUS:
                    s_nxt.rdata = {31'h0000_0000, s_r.tgt_hit};
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r      <= '0;
            s_r.ctrl <= ptp_ctl_pkg::CTRL_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata       = s_r.rdata;
    assign rx_snap_valid   = s_r.rx_snap;
    assign tx_snap_valid   = s_r.tx_snap;
    assign snap_sec        = s_r.snap_sec;
    assign snap_ns         = s_r.snap_ns;
    assign rx_ptp_process  = s_r.rx_proc;
    assign target_time_irq = s_r.irq;
endmodule // ptp_system_time_control

//--- testbench/ptp_system_time_control_assertions.sv
// port assertions for the ptp system time control block
// bound from the bench onto the top module, one clock domain
module ptp_system_time_control_assertions (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // register port
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // frame events
    input wire logic        rx_frame_end,
    input wire logic        tx_frame_end,
    input wire logic        tx_ts_request,
    // results
    input wire logic        rx_snap_valid,
    input wire logic        tx_snap_valid,
    input wire logic [31:0] snap_sec,
    input wire logic [31:0] snap_ns,
    input wire logic        rx_ptp_process,
    input wire logic        target_time_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_tx_req;
        tx_frame_end && tx_ts_request && !rx_frame_end && rx_ptp_process;
    endsequence
    sequence s_irq_pulse;
        target_time_irq ##1 !target_time_irq;
    endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_rx_snap_cause: assert property
        (rx_snap_valid |-> $past(rx_frame_end))
        else $error("rx snapshot without frame end");
    a_tx_snap_cause: assert property
        (tx_snap_valid |-> $past(tx_frame_end && tx_ts_request))
        else $error("tx snapshot without request");
    a_snap_gated: assert property
        (rx_snap_valid || tx_snap_valid |-> rx_ptp_process)
        else $error("snapshot while disabled");
    a_snap_excl: assert property (!(rx_snap_valid && tx_snap_valid))
        else $error("two snapshots at once");
    a_snap_hold: assert property (!rx_snap_valid && !tx_snap_valid
        |-> $stable(snap_sec) && $stable(snap_ns))
        else $error("snapshot value moved");
    a_tx_snap_taken: assert property (s_tx_req ##1 rx_ptp_process
        |-> tx_snap_valid)
        else $error("tx snapshot missing");
    a_irq_single: assert property (target_time_irq |-> s_irq_pulse)
        else $error("target interrupt longer than one cycle");
endmodule // ptp_system_time_control_assertions

//--- testbench/mac_frame_model.sv
// model of the mac receive and transmit paths
// frames are requested by task calls from the bench
module mac_frame_model (
    // clock
    input wire logic core_clk,
    // frame events
    output logic       rx_frame_end,
    output logic       rx_is_ptp,
    output logic [3:0] rx_msg_type,
    output logic       tx_frame_end,
    output logic       tx_ts_request
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rx_frame_end = 1'b0;
        rx_is_ptp = 1'b0;
        rx_msg_type = 4'h0;
        tx_frame_end = 1'b0;
        tx_ts_request = 1'b0;
    end
    // qualifiers inverted outside the frame end cycle
    task automatic frame(input logic rx, input logic p, input logic [3:0] t,
                         input logic tx);
        @(posedge core_clk);
        rx_frame_end <= rx;
        rx_is_ptp <= p;
        rx_msg_type <= t;
        tx_frame_end <= tx;
        tx_ts_request <= tx;
        @(posedge core_clk);
        rx_frame_end <= 1'b0;
        tx_frame_end <= 1'b0;
        rx_is_ptp <= ~p;
        rx_msg_type <= ~t;
        tx_ts_request <= ~tx;
    endtask
endmodule // mac_frame_model

//--- testbench/ptp_system_time_control_tb.sv
// self-checking bench for the ptp system time control block
// drives the register port and the frame model on core_clk
module ptp_system_time_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0]  CT = ptp_ctl_pkg::OFS_CTRL;
    localparam logic [31:0] ON = 32'h1;
    logic        core_clk, rst_b, reg_wr, reg_rd;
    logic [3:0]  reg_addr, rx_msg_type, t;
    logic [31:0] reg_wdata, reg_rdata, snap_sec, snap_ns, v, s, n, a, b;
    logic        rx_frame_end, rx_is_ptp, tx_frame_end, tx_ts_request, e;
    logic        rx_snap_valid, tx_snap_valid, rx_ptp_process;
    logic        target_time_irq;
    logic [3:0]  msgs [7];
    int          n_mismatch, tests_run, i;
    integer      seed;
    ptp_system_time_control ptp_system_time_control_i (.*);
    mac_frame_model mac_frame_model_i (.*);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    function automatic logic want(logic [1:0] c, logic eo, logic ms,
                                  logic [3:0] m);
        logic f, p, y;
        y = m == ptp_ctl_pkg::MSG_SYNC;
        f = m inside {ptp_ctl_pkg::MSG_SYNC, ptp_ctl_pkg::MSG_FOLLOW_UP,
            ptp_ctl_pkg::MSG_DELAY_REQ, ptp_ctl_pkg::MSG_DELAY_RESP};
        p = m inside {ptp_ctl_pkg::MSG_PDLY_REQ, ptp_ctl_pkg::MSG_PDLY_RESP};
        if (c == 2'd3) return eo ? y || p : f || p;
        if (c == 2'd2) return eo ? y || m == ptp_ctl_pkg::MSG_FOLLOW_UP : f;
        return eo ? m == (ms ? ptp_ctl_pkg::MSG_DELAY_REQ : 4'h0) : f;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task automatic wait_clr(input int k);
        logic [31:0] c;
        for (int j = 0; j < 20; j++) begin
            rd(CT, c);
            if (c[k] === 1'b0) return;
        end
        chk(c, 32'h0);
        close_out();
    endtask
    task automatic init_t(input logic [31:0] c, sc, ns);
        wr(ptp_ctl_pkg::OFS_SEC_UPD, sc);
        wr(ptp_ctl_pkg::OFS_NS_UPD, ns);
        wr(CT, c | 32'h4);
        wait_clr(ptp_ctl_pkg::BIT_INIT);
    endtask
    task automatic snap(output logic [31:0] sc, ns);
        mac_frame_model_i.frame(1'b0, 1'b0, 4'h0, 1'b1);
        @(negedge core_clk);
        chk({31'h0, tx_snap_valid}, 32'h1);
        sc = snap_sec;
        ns = snap_ns;
    endtask
    initial begin
        seed = 32'h6a18;
        n_mismatch = 0;
        tests_run = 0;
        {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        msgs = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hB};
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(CT, v);
        chk(v, ptp_ctl_pkg::CTRL_RESET);
        rd(4'hA, v);
        chk(v, 32'h0);
        v = $random(seed) & ~32'h3C;
        wr(CT, v);
        rd(CT, a);
        chk(a, v & ptp_ctl_pkg::CTRL_WMASK);
        $display("register test done");
        wr(ptp_ctl_pkg::OFS_INC, 32'h1);
        for (int k = 0; k < 3; k++) begin
            s = $random(seed);
            n = {1'b0, k == 1 ? ptp_ctl_pkg::BINARY_MAX
                : ptp_ctl_pkg::DIGITAL_MAX} - 32'h3;
            init_t(k == 0 ? 32'h201 : ON, s, n);
            repeat (8) @(posedge core_clk);
            snap(a, b);
            chk(a, k == 2 ? s : s + 32'h1);
            e = k == 2 ? b[30:0] > n[30:0] : b[30:0] < 31'd20;
            chk({31'h0, e}, 32'h1);
        end
        $display("rollover test done");
        wr(ptp_ctl_pkg::OFS_INC, 32'h0);
        for (int k = 0; k < 2; k++) begin
            s = $random(seed) & 32'h3FFF_FFFF | 32'h4000_0000;
            n = $random(seed) & 32'h1FFF_FFFF | 32'h2000_0000;
            a = $random(seed) & 32'h0FFF_FFFF;
            b = $random(seed) & 32'h0FFF_FFFF;
            init_t(ON, s, n);
            wr(ptp_ctl_pkg::OFS_SEC_UPD, a);
            wr(ptp_ctl_pkg::OFS_NS_UPD, b | (k << 31));
            wr(CT, ON | 32'h8);
            wait_clr(ptp_ctl_pkg::BIT_UPDATE);
            rd(ptp_ctl_pkg::OFS_SEC, v);
            chk(v, k ? s - a : s + a);
            rd(ptp_ctl_pkg::OFS_NS, v);
            chk({1'b0, v[30:0]}, k ? n - b : n + b);
        end
        $display("update test done");
        wr(ptp_ctl_pkg::OFS_INC, 32'h1);
        for (int k = 0; k < 4; k++) begin
            wr(ptp_ctl_pkg::OFS_ADDEND, k == 2 ? 32'h0 : 32'h8000_0000);
            wr(CT, k == 3 ? 32'h3 : k ? 32'h23 : ON);
            if (k == 1 || k == 2)
                wait_clr(ptp_ctl_pkg::BIT_ADDEND);
            snap(s, n);
            repeat (8) @(posedge core_clk);
            snap(s, b);
            v = k == 0 ? 32'd10 : k == 1 ? 32'd5 : 32'd0;
            chk(b - n, v);
        end
        $display("correction test done");
        wr(CT, 32'h0);
        rd(ptp_ctl_pkg::OFS_NS, a);
        repeat (5) @(posedge core_clk);
        rd(ptp_ctl_pkg::OFS_NS, b);
        chk(b, a);
        mac_frame_model_i.frame(1'b1, 1'b1, 4'h0, 1'b1);
        @(negedge core_clk);
        v = {29'h0, rx_snap_valid, tx_snap_valid, rx_ptp_process};
        chk(v, 32'h0);
        $display("disable test done");
        for (int m = 0; m < 32; m++) begin
            wr(CT, {14'h0, m[1:0], m[3], m[2], 5'h0, m[4], 8'h1});
            for (int j = 0; j < 8; j++) begin
                t = j < 7 ? msgs[j] : 4'($random(seed));
                mac_frame_model_i.frame(1'b1, j < 7, t, 1'b1);
                @(negedge core_clk);
                e = m[4] || (j < 7 && want(m[1:0], m[2], m[3], t));
                v = {30'h0, rx_snap_valid, tx_snap_valid};
                chk(v, {30'h0, e, !e});
            end
        end
        $display("snapshot selection test done");
        s = $random(seed);
        init_t(ON, s, 32'h0);
        wr(ptp_ctl_pkg::OFS_TGT_SEC, s);
        wr(ptp_ctl_pkg::OFS_TGT_NS, 32'd60);
        wr(CT, ON | 32'h10);
        for (i = 0; i < 200 && target_time_irq !== 1'b1; i++)
            @(negedge core_clk);
        chk({31'h0, target_time_irq}, 32'h1);
        snap(a, b);
        chk({31'h0, b[30:0] > 31'd60 && b[30:0] < 31'd75}, 32'h1);
        rd(CT, v);
        chk({31'h0, v[4]}, 32'h0);
        rd(ptp_ctl_pkg::OFS_STATUS, v);
        chk(v, 32'h1);
        $display("target test done");
        @(posedge core_clk);
        rst_b <= 1'b0;
        @(posedge core_clk);
        rst_b <= 1'b1;
        rd(CT, v);
        chk(v, ptp_ctl_pkg::CTRL_RESET);
        chk(snap_sec | snap_ns, 32'h0);
        $display("reset test done");
        close_out();
    end
endmodule // ptp_system_time_control_tb
bind ptp_system_time_control ptp_system_time_control_assertions
    ptp_system_time_control_assertions_i (.*);
